// ### bench/abf_ctrl_model.sv
// Controller model that drives the strobe side of one byte FIFO channel
`timescale 1ns/1ps
module abf_ctrl_model (
    input wire logic clk_sys_in,
    input wire logic [7:0] bus_in,
    input wire logic rx_avail_n_in,
    input wire logic tx_space_n_in,
    output logic rd_n_out,
    output logic wr_n_out,
    output logic wake_n_out,
    output logic [7:0] drv_data_out
);
    // ------------------------------------------------------------
    // Strobe tasks
    // ------------------------------------------------------------
    initial
    begin
        rd_n_out = 1'h1;
        wr_n_out = 1'h1;
        wake_n_out = 1'h1;
        drv_data_out = 8'h5a;
    end

    // Each phase outlasts the two sync stages of the port
    task automatic hold(input int n);
        repeat (n) @(posedge clk_sys_in);
        #2;
    endtask : hold

    task automatic read_byte(output logic [7:0] got, output logic fl_before, output logic fl_during);
        for (int i = 0; i < 300 && rx_avail_n_in !== 1'h0; i++) hold(1);
        fl_before = rx_avail_n_in;
        rd_n_out = 1'h0;
        hold(5);
        got = bus_in;
        fl_during = rx_avail_n_in;
        rd_n_out = 1'h1;
        hold(5);
    endtask : read_byte

    task automatic write_byte(input logic [7:0] b, input bit wait_space);
        for (int i = 0; i < 300 && wait_space && tx_space_n_in !== 1'h0; i++) hold(1);
        drv_data_out = b;
        wr_n_out = 1'h0;
        hold(4);
        wr_n_out = 1'h1;
        hold(2);
        drv_data_out = ~b;
        hold(2);
    endtask : write_byte

    task automatic wake_pulse;
        hold(3);
        wake_n_out = 1'h0;
        hold(4);
        wake_n_out = 1'h1;
        hold(4);
    endtask : wake_pulse
endmodule : abf_ctrl_model

// ### bench/tb.sv
// Self-checking testbench for one byte FIFO port channel
`timescale 1ns/1ps
module tb;
    logic clk_sys_in, reset_n_in, mode_fifo_en_in, remote_wake_en_in, power_enable_n_in;
    logic rd_n, wr_n, wake_n, rx_valid_in, tx_ready_in;
    logic [7:0] drv_data, bus, data_bus_out, rx_data_in, tx_data_out, got, b;
    logic data_bus_oe_out, rx_avail_n_out, rx_avail_n_oe_out, tx_space_n_out, tx_space_n_oe_out;
    logic rx_ready_out, tx_valid_out, flush_req_out, resume_req_out, rx_flag, tx_flag, f0, f1;
    logic [7:0] n_flush, n_resume, exp_k;
    logic [7:0] rx_q[$], tx_q[$], got_q[$];
    int n_fail, checks_done, seed;

    assign bus = data_bus_oe_out ? data_bus_out : drv_data;
    assign rx_flag = rx_avail_n_oe_out ? rx_avail_n_out : 1'h1;
    assign tx_flag = tx_space_n_oe_out ? tx_space_n_out : 1'h1;

    abf_port abf_port_inst (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
        .mode_fifo_en_in(mode_fifo_en_in), .remote_wake_en_in(remote_wake_en_in),
        .power_enable_n_in(power_enable_n_in), .rd_n_in(rd_n), .wr_n_in(wr_n),
        .send_now_wake_n_in(wake_n), .data_bus_in(bus), .data_bus_out(data_bus_out),
        .data_bus_oe_out(data_bus_oe_out), .rx_avail_n_out(rx_avail_n_out),
        .rx_avail_n_oe_out(rx_avail_n_oe_out), .tx_space_n_out(tx_space_n_out),
        .tx_space_n_oe_out(tx_space_n_oe_out), .rx_valid_in(rx_valid_in), .rx_data_in(rx_data_in),
        .rx_ready_out(rx_ready_out), .tx_valid_out(tx_valid_out), .tx_data_out(tx_data_out),
        .tx_ready_in(tx_ready_in), .flush_req_out(flush_req_out), .resume_req_out(resume_req_out));

    abf_ctrl_model abf_ctrl_model_inst (.clk_sys_in(clk_sys_in), .bus_in(bus), .rx_avail_n_in(rx_flag),
        .tx_space_n_in(tx_flag), .rd_n_out(rd_n), .wr_n_out(wr_n), .wake_n_out(wake_n),
        .drv_data_out(drv_data));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    initial
    begin
        clk_sys_in = 1'h0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end

    // Sampled mid-cycle, where the handshake of the coming edge is settled
    always @(negedge clk_sys_in)
    begin
        if (tx_valid_out === 1'h1 && tx_ready_in === 1'h1)
            got_q.push_back(tx_data_out);
        if (flush_req_out === 1'h1)
            n_flush++;
        if (resume_req_out === 1'h1)
            n_resume++;
    end

    // Bit 1 resume, bit 0 flush
    function automatic logic [1:0] wake_kind(input logic pwr_n, input logic wake_en);
        return pwr_n ? {wake_en, 1'h0} : 2'h1;
    endfunction : wake_kind

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic feed_all;
        logic r;
        foreach (rx_q[i])
        begin
            rx_valid_in = 1'h1;
            rx_data_in = rx_q[i];
            for (int k = 0; k < 500; k++)
            begin
                @(negedge clk_sys_in);
                r = rx_ready_out;
                @(posedge clk_sys_in);
                if (r === 1'h1)
                    break;
            end
            #2;
        end
        rx_valid_in = 1'h0;
    endtask : feed_all

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim

    initial
    begin
        #(20 * 20000);
        n_fail++;
        end_sim();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        seed = 88900;
        {reset_n_in, remote_wake_en_in, power_enable_n_in, rx_valid_in, tx_ready_in} = 5'h0;
        {mode_fifo_en_in, rx_data_in, n_flush, n_resume} = {1'h1, 24'h0};
        repeat (12) @(posedge clk_sys_in);
        #2;
        check(rx_avail_n_oe_out, 1'h0, "rx flag driven in reset");
        check(tx_space_n_oe_out, 1'h0, "tx flag driven in reset");
        reset_n_in = 1'h1;
        abf_ctrl_model_inst.hold(4);
        check(rx_avail_n_oe_out, 1'h1, "rx flag not driven");
        check(tx_flag, 1'h0, "no tx space");
        $display("test reset done");
        rx_q = '{8'hff, 8'h00};
        repeat (6) rx_q.push_back(8'($random(seed)));
        fork
            feed_all();
        join_none
        foreach (rx_q[i])
        begin
            abf_ctrl_model_inst.read_byte(got, f0, f1);
            check(f0, 1'h0, "rx flag before read");
            check(got, rx_q[i], "read byte");
            check(f1, 1'h1, "rx flag during read");
            check(data_bus_oe_out, 1'h0, "bus driven after read");
        end
        check(rx_flag, 1'h1, "rx flag with nothing left");
        $display("test read done");
        for (int i = 0; i < 3; i++)
        begin
            b = 8'($random(seed));
            if (i < 2)
                tx_q.push_back(b);
            abf_ctrl_model_inst.write_byte(b, 1'b0);
            check(tx_flag, i > 0, "tx flag while stalled");
        end
        for (int i = 0; i < 4; i++)
        begin
            b = 8'($random(seed));
            tx_q.push_back(b);
            fork
                abf_ctrl_model_inst.write_byte(b, 1'b1);
                begin
                    repeat (12)
                    begin
                        abf_ctrl_model_inst.hold(1);
                        tx_ready_in = 1'($random(seed));
                    end
                    // Left ready, so a write still waiting for space cannot stall for good
                    abf_ctrl_model_inst.hold(1);
                    tx_ready_in = 1'h1;
                end
            join
        end
        abf_ctrl_model_inst.hold(6);
        check(8'(got_q.size()), 8'(tx_q.size()), "tx count");
        foreach (tx_q[i])
            check(got_q[i], tx_q[i], "tx byte");
        $display("test write done");
        for (int k = 0; k < 5; k++)
        begin
            {power_enable_n_in, remote_wake_en_in} = 2'(k);
            mode_fifo_en_in = (k < 4);
            exp_k = {6'h0, mode_fifo_en_in ? wake_kind(k[1], k[0]) : 2'h0};
            {n_flush, n_resume} = 16'h0;
            abf_ctrl_model_inst.wake_pulse();
            check(n_flush, exp_k[0], "flush pulses");
            check(n_resume, exp_k[1], "resume pulses");
        end
        check(tx_space_n_oe_out, 1'h0, "tx flag driven with mode off");
        $display("test wake done");
        end_sim();
    end
endmodule : tb

// ### verilog/abf_pkg.sv
// Shared constants for the asynchronous byte FIFO port
package abf_pkg;

    // ------------------------------------------------------------
    // Widths and depths
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int BUF_DEPTH = 2;
    localparam int BUF_CNT_W = 2;
    localparam int BUF_PTR_W = 1;

    // ------------------------------------------------------------
    // Values after reset, and the full count
    // ------------------------------------------------------------
    localparam logic STROBE_IDLE = 1'h1;
    localparam logic FLAG_IDLE_N = 1'h1;
    localparam logic OE_RESET = 1'h0;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
    localparam logic [BUF_CNT_W-1:0] CNT_EMPTY = 2'h0;
    localparam logic [BUF_CNT_W-1:0] CNT_FULL = 2'h2;
    localparam logic [BUF_PTR_W-1:0] PTR_RESET = 1'h0;

endpackage : abf_pkg

// ### verilog/abf_port.sv
// One channel of the asynchronous byte FIFO port
`timescale 1ns/1ps
module abf_port (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic mode_fifo_en_in,
    input wire logic remote_wake_en_in,
    input wire logic power_enable_n_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    input wire logic send_now_wake_n_in,
    input wire logic [abf_pkg::DATA_W-1:0] data_bus_in,
    output logic [abf_pkg::DATA_W-1:0] data_bus_out,
    output logic data_bus_oe_out,
    output logic rx_avail_n_out,
    output logic rx_avail_n_oe_out,
    output logic tx_space_n_out,
    output logic tx_space_n_oe_out,
    input wire logic rx_valid_in,
    input wire logic [abf_pkg::DATA_W-1:0] rx_data_in,
    output logic rx_ready_out,
    output logic tx_valid_out,
    output logic [abf_pkg::DATA_W-1:0] tx_data_out,
    input wire logic tx_ready_in,
    output logic flush_req_out,
    output logic resume_req_out
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic rd_s1_reg;
    logic rd_s2_reg;
    logic rd_prev_reg;
    logic wr_s1_reg;
    logic wr_s2_reg;
    logic wr_prev_reg;
    logic wake_s1_reg;
    logic wake_s2_reg;
    logic wake_prev_reg;
    logic [abf_pkg::DATA_W-1:0] data_s1_reg;
    logic [abf_pkg::DATA_W-1:0] data_s2_reg;
    logic rd_fall;
    logic rd_rise;
    logic wr_fall;
    logic wake_fall;

    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            rd_s1_reg <= abf_pkg::STROBE_IDLE;
            rd_s2_reg <= abf_pkg::STROBE_IDLE;
            rd_prev_reg <= abf_pkg::STROBE_IDLE;
            wr_s1_reg <= abf_pkg::STROBE_IDLE;
            wr_s2_reg <= abf_pkg::STROBE_IDLE;
            wr_prev_reg <= abf_pkg::STROBE_IDLE;
            wake_s1_reg <= abf_pkg::STROBE_IDLE;
            wake_s2_reg <= abf_pkg::STROBE_IDLE;
            wake_prev_reg <= abf_pkg::STROBE_IDLE;
            data_s1_reg <= abf_pkg::DATA_RESET;
            data_s2_reg <= abf_pkg::DATA_RESET;
        end
        else
        begin
            rd_s1_reg <= rd_n_in;
            rd_s2_reg <= rd_s1_reg;
            rd_prev_reg <= rd_s2_reg;
            wr_s1_reg <= wr_n_in;
            wr_s2_reg <= wr_s1_reg;
            wr_prev_reg <= wr_s2_reg;
            wake_s1_reg <= send_now_wake_n_in;
            wake_s2_reg <= wake_s1_reg;
            wake_prev_reg <= wake_s2_reg;
            data_s1_reg <= data_bus_in;
            data_s2_reg <= data_s1_reg;
        end
    end

    // Edges are seen only when the port is in FIFO mode
    assign rd_fall = mode_fifo_en_in && rd_prev_reg && !rd_s2_reg;
    assign rd_rise = mode_fifo_en_in && !rd_prev_reg && rd_s2_reg;
    assign wr_fall = mode_fifo_en_in && wr_prev_reg && !wr_s2_reg;
    // A wake input held low since reset still gives one edge once reset ends, as the stages reset high
    assign wake_fall = mode_fifo_en_in && wake_prev_reg && !wake_s2_reg;

    // ------------------------------------------------------------
    // Receive side
    // ------------------------------------------------------------
    logic hold_valid_reg;
    logic [abf_pkg::DATA_W-1:0] hold_data_reg;
    logic [abf_pkg::DATA_W-1:0] out_data_reg;
    logic data_oe_reg;
    logic rx_avail_n_reg;

    assign rx_ready_out = mode_fifo_en_in && !hold_valid_reg;

    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            hold_valid_reg <= 1'h0;
            hold_data_reg <= abf_pkg::DATA_RESET;
        end
        else if (rd_rise && hold_valid_reg)
        begin
            hold_valid_reg <= 1'h0;
        end
        else if (rx_valid_in && rx_ready_out)
        begin
            hold_valid_reg <= 1'h1;
            hold_data_reg <= rx_data_in;
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            out_data_reg <= abf_pkg::DATA_RESET;
        end
        else if (rd_fall)
        begin
            out_data_reg <= hold_data_reg;
        end
    end

    // Bus turns round three cycles after the pin, so the controller must allow access time
    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            data_oe_reg <= abf_pkg::OE_RESET;
        end
        else
        begin
            data_oe_reg <= mode_fifo_en_in && !rd_s2_reg;
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            rx_avail_n_reg <= abf_pkg::FLAG_IDLE_N;
        end
        else
        begin
            // Strobe rising in this cycle keeps the flag high for at least one cycle
            rx_avail_n_reg <= !(mode_fifo_en_in && hold_valid_reg && rd_s2_reg && rd_prev_reg);
        end
    end

    assign data_bus_out = out_data_reg;
    assign data_bus_oe_out = data_oe_reg;

    // ------------------------------------------------------------
    // Transmit side
    // ------------------------------------------------------------
    logic buf_in_ready;
    logic tx_space_n_reg;

    // A write while the buffer is full is dropped; the buffer never overflows
    abf_skid_buf #(
        .WIDTH(abf_pkg::DATA_W),
        .DEPTH(abf_pkg::BUF_DEPTH)
    ) u_tx_buf (
        .clk_sys_in(clk_sys_in),
        .reset_n_in(reset_n_in),
        .in_valid_in(wr_fall),
        .in_data_in(data_s2_reg),
        .in_ready_out(buf_in_ready),
        .out_valid_out(tx_valid_out),
        .out_data_out(tx_data_out),
        .out_ready_in(tx_ready_in)
    );

    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            tx_space_n_reg <= abf_pkg::FLAG_IDLE_N;
        end
        else
        begin
            tx_space_n_reg <= !(mode_fifo_en_in && buf_in_ready && !wr_fall);
        end
    end

    // ------------------------------------------------------------
    // Flag drivers
    // ------------------------------------------------------------
    logic flags_oe_reg;

    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            flags_oe_reg <= abf_pkg::OE_RESET;
        end
        else
        begin
            flags_oe_reg <= mode_fifo_en_in;
        end
    end

    assign rx_avail_n_out = rx_avail_n_reg;
    assign rx_avail_n_oe_out = flags_oe_reg;
    assign tx_space_n_out = tx_space_n_reg;
    assign tx_space_n_oe_out = flags_oe_reg;

    // ------------------------------------------------------------
    // Send-now and wakeup
    // ------------------------------------------------------------
    logic flush_reg;
    logic resume_reg;

    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            flush_reg <= 1'h0;
            resume_reg <= 1'h0;
        end
        else
        begin
            flush_reg <= wake_fall && !power_enable_n_in;
            resume_reg <= wake_fall && power_enable_n_in && remote_wake_en_in;
        end
    end

    assign flush_req_out = flush_reg;
    assign resume_req_out = resume_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!reset_n_in);

    sequence s_read_end;
        rd_rise && hold_valid_reg;
    endsequence

    sequence s_flag_high_then_wait;
        rx_avail_n_out && !hold_valid_reg;
    endsequence

    sequence s_wake_suspended;
        wake_fall && power_enable_n_in && remote_wake_en_in;
    endsequence

    sequence s_resume_pulse;
        resume_req_out ##1 !resume_req_out;
    endsequence

    // Reset must have been seen at one edge already, so a missed reset edge at start gives no false alarm
    sequence s_held_reset;
        !reset_n_in ##1 !reset_n_in;
    endsequence

    a_mode_gate_read: assert property ((!mode_fifo_en_in && rd_s2_reg) |=> !data_bus_oe_out)
        else $error("bus driven outside FIFO mode");
    a_read_latch_byte: assert property (rd_fall |=> (data_bus_out == $past(hold_data_reg)))
        else $error("read byte not latched on strobe fall");
    a_bus_input_idle: assert property (rd_s2_reg |=> !data_bus_oe_out)
        else $error("bus driven while read strobe high");
    a_read_flag_valid: assert property (!rx_avail_n_out |-> $past(hold_valid_reg))
        else $error("receive flag low with no byte");
    a_flag_rises_read: assert property (s_read_end |=> s_flag_high_then_wait)
        else $error("flag or byte did not clear after read");
    a_tx_flag_full: assert property (!buf_in_ready |=> tx_space_n_out)
        else $error("transmit flag low while buffer full");
    a_write_capture_byte: assert property ((wr_fall && buf_in_ready) |=> tx_valid_out)
        else $error("written byte not captured");
    a_wake_resume_pulse: assert property (s_wake_suspended |=> s_resume_pulse)
        else $error("resume request missing or too long");
    a_send_now_flush: assert property ((wake_fall && !power_enable_n_in) |=> flush_req_out && !resume_req_out)
        else $error("flush request missing");
    a_reset_float_flags: assert property (@(posedge clk_sys_in) disable iff (1'b0) s_held_reset
        |-> (!rx_avail_n_oe_out && !tx_space_n_oe_out))
        else $error("flags driven during reset");

endmodule : abf_port

// ### verilog/abf_skid_buf.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module abf_skid_buf #(
    parameter int WIDTH = abf_pkg::DATA_W,
    parameter int DEPTH = abf_pkg::BUF_DEPTH
) (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [abf_pkg::BUF_PTR_W-1:0] wr_ptr_reg;
    logic [abf_pkg::BUF_PTR_W-1:0] rd_ptr_reg;
    logic [abf_pkg::BUF_CNT_W-1:0] count_reg;
    logic push;
    logic pop;

    assign in_ready_out = (count_reg != abf_pkg::CNT_FULL);
    assign out_valid_out = (count_reg != abf_pkg::CNT_EMPTY);
    assign out_data_out = mem_reg[rd_ptr_reg];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    // ------------------------------------------------------------
    // Storage and pointers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                mem_reg[i] <= '0;
            end
        end
        else if (push)
        begin
            mem_reg[wr_ptr_reg] <= in_data_in;
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            wr_ptr_reg <= abf_pkg::PTR_RESET;
            rd_ptr_reg <= abf_pkg::PTR_RESET;
            count_reg <= abf_pkg::CNT_EMPTY;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop)
            begin
                count_reg <= count_reg + 1'b1;
            end
            else if (pop && !push)
            begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

endmodule : abf_skid_buf
